/* verilog/sdma_pkg.sv */
package sdma_pkg;

    // ****************************************
    // register indices (byte address = index * 4)
    // ****************************************
    localparam logic [13:0] REG_TRIG_IDX     = 14'h3E00;
    localparam logic [13:0] REG_MODE_IDX     = 14'h3E01;
    localparam logic [13:0] REG_EN_IDX       = 14'h3E02;
    localparam logic [13:0] REG_STAT_IDX     = 14'h3E03;
    localparam logic [13:0] REG_SRC_LO_IDX   = 14'h3E04;
    localparam logic [13:0] REG_SRC_MID_IDX  = 14'h3E05;
    localparam logic [13:0] REG_SRC_HI_IDX   = 14'h3E06;
    localparam logic [13:0] REG_DST_LO_IDX   = 14'h3E08;
    localparam logic [13:0] REG_DST_MID_IDX  = 14'h3E09;
    localparam logic [13:0] REG_DST_HI_IDX   = 14'h3E0A;
    localparam logic [13:0] REG_CNT_LO_IDX   = 14'h3E0C;
    localparam logic [13:0] REG_CNT_HI_IDX   = 14'h3E0D;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          BIT_SRC_FIXED = 7;
    localparam int          BIT_UNIT_SIZE = 5;
    localparam int          BIT_MODE      = 3;
    localparam int          BIT_DST_FIXED = 1;
    localparam int          BIT_ENABLE    = 0;
    localparam int          BIT_ERROR     = 4;
    localparam int          BIT_BUSY      = 0;
    localparam logic [4:0]  TRIG_SOFTWARE = 5'h00;
    localparam logic [16:0] ADDR_RESET    = 17'h00000;
    localparam logic [9:0]  CNT_RESET     = 10'h000;
    localparam logic [9:0]  CNT_LAST      = 10'h001;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ****************************************
    // memory bus request carrier
    // ****************************************
    typedef struct packed {
        logic        we;
        logic        wide;
        logic [16:0] addr;
        logic [15:0] wdata;
    } sdma_mem_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_READ,
        ST_WRITE
    } sdma_state_t;

endpackage

/* verilog/sdma_top.sv */
`timescale 1ns/1ps

module sdma_top
    import sdma_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_rst_n,
    input  wire logic [15:0]   i_awaddr,
    input  wire logic          i_awvalid,
    output logic               o_awready,
    input  wire logic [31:0]   i_wdata,
    input  wire logic [3:0]    i_wstrb,
    input  wire logic          i_wvalid,
    output logic               o_wready,
    output logic [1:0]         o_bresp,
    output logic               o_bvalid,
    input  wire logic          i_bready,
    input  wire logic [15:0]   i_araddr,
    input  wire logic          i_arvalid,
    output logic               o_arready,
    output logic [31:0]        o_rdata,
    output logic [1:0]         o_rresp,
    output logic               o_rvalid,
    input  wire logic          i_rready,
    output logic               o_mem_valid,
    output sdma_mem_req_t      o_mem,
    input  wire logic          i_mem_ready,
    input  wire logic [15:0]   i_mem_rdata,
    input  wire logic [31:0]   i_trigger,
    output logic               o_done_irq,
    output logic               o_addreq_irq,
    output logic               o_error_irq
);

    // ****************************************
    // helper functions
    // ****************************************
    function automatic logic is_mapped(input logic [13:0] idx);
        is_mapped = (idx >= REG_TRIG_IDX && idx <= REG_SRC_HI_IDX)
                 || (idx >= REG_DST_LO_IDX && idx <= REG_DST_HI_IDX)
                 || idx == REG_CNT_LO_IDX || idx == REG_CNT_HI_IDX;
    endfunction

    // advance by unit size unless the address is held fixed
    function automatic logic [16:0] step_addr(input logic [16:0] a, input logic fixed,
                                              input logic wide);
        step_addr = fixed ? a : a + {15'h0000, wide, ~wide};
    endfunction

    // ****************************************
    // state
    // ****************************************
    sdma_state_t   state;
    logic [4:0]    trig_sel;
    logic          src_fixed;
    logic          dst_fixed;
    logic          unit_wide;
    logic          mode_single;
    logic          enable;
    logic          busy;
    logic          error_flag;
    logic          last_read;
    logic [16:0]   src;
    logic [16:0]   dst;
    logic [9:0]    count;
    logic [15:0]   data_hold;
    logic          aw_full;
    logic          w_full;
    logic [15:0]   aw_addr;
    logic [7:0]    w_byte;
    logic          w_lane0;

    // ****************************************
    // register bus decode
    // ****************************************
    wire           aw_take   = i_awvalid & o_awready;
    wire           w_take    = i_wvalid & o_wready;
    wire           wr_fire   = aw_full & w_full & ~o_bvalid;
    wire [13:0]    wr_idx    = aw_addr[15:2];
    wire           wr_ok     = (aw_addr[1:0] == 2'h0) & is_mapped(wr_idx);
    wire           wr_en     = wr_fire & wr_ok & w_lane0;
    wire           ar_take   = i_arvalid & o_arready;
    wire [13:0]    rd_idx    = i_araddr[15:2];
    wire           rd_ok     = (i_araddr[1:0] == 2'h0) & is_mapped(rd_idx);

    // per-register write strobes
    wire           wr_trig   = wr_en & (wr_idx == REG_TRIG_IDX);
    wire           wr_mode   = wr_en & (wr_idx == REG_MODE_IDX);
    wire           wr_enreg  = wr_en & (wr_idx == REG_EN_IDX);
    wire           wr_src_lo = wr_en & (wr_idx == REG_SRC_LO_IDX);
    wire           wr_src_md = wr_en & (wr_idx == REG_SRC_MID_IDX);
    wire           wr_src_hi = wr_en & (wr_idx == REG_SRC_HI_IDX);
    wire           wr_dst_lo = wr_en & (wr_idx == REG_DST_LO_IDX);
    wire           wr_dst_md = wr_en & (wr_idx == REG_DST_MID_IDX);
    wire           wr_dst_hi = wr_en & (wr_idx == REG_DST_HI_IDX);
    wire           wr_cnt_lo = wr_en & (wr_idx == REG_CNT_LO_IDX);
    wire           wr_cnt_hi = wr_en & (wr_idx == REG_CNT_HI_IDX);
    wire           en_set    = wr_enreg & w_byte[BIT_ENABLE];
    wire           en_stop   = wr_enreg & ~w_byte[BIT_ENABLE];

    // next values of the bus handshake flops
    wire           next_aw_full = (aw_full | aw_take) & ~wr_fire;
    wire           next_w_full  = (w_full | w_take) & ~wr_fire;
    wire           next_bvalid  = o_bvalid ? ~i_bready : wr_fire;
    wire           next_rvalid  = o_rvalid ? ~i_rready : ar_take;

    // read-back selection; reserved bits read as zero
    wire [7:0]     mode_rb   = {2'h0, unit_wide, 1'h0, mode_single, 1'h0, dst_fixed, 1'h0};
    wire [7:0]     rd_byte =
        (rd_idx == REG_TRIG_IDX)    ? {src_fixed, 2'b00, trig_sel} :
        (rd_idx == REG_MODE_IDX)    ? mode_rb :
        (rd_idx == REG_EN_IDX)      ? {7'h00, enable} :
        (rd_idx == REG_STAT_IDX)    ? {3'h0, error_flag, 3'h0, busy} :
        (rd_idx == REG_SRC_LO_IDX)  ? src[7:0] :
        (rd_idx == REG_SRC_MID_IDX) ? src[15:8] :
        (rd_idx == REG_SRC_HI_IDX)  ? {7'h00, src[16]} :
        (rd_idx == REG_DST_LO_IDX)  ? dst[7:0] :
        (rd_idx == REG_DST_MID_IDX) ? dst[15:8] :
        (rd_idx == REG_DST_HI_IDX)  ? {7'h00, dst[16]} :
        (rd_idx == REG_CNT_LO_IDX)  ? count[7:0] :
        (rd_idx == REG_CNT_HI_IDX)  ? {6'h00, count[9:8]} : 8'h00;

    // ****************************************
    // transfer decode
    // ****************************************
    wire           mem_done  = o_mem_valid & i_mem_ready;
    wire           rd_done   = (state == ST_READ) & mem_done;
    wire           wr_done   = (state == ST_WRITE) & mem_done;
    wire           last_unit = (count == CNT_LAST);
    wire           sw_trig   = (trig_sel == TRIG_SOFTWARE);
    wire           trig_evt  = ~sw_trig & i_trigger[trig_sel];
    // software trigger fires continuously while waiting
    wire           start     = (state == ST_WAIT) & ~en_stop
                             & (sw_trig | trig_evt);
    // single mode: pending unit not yet read; burst: last unit not yet read
    wire           err_evt   = trig_evt & busy & ~last_read & ~en_stop
                             & (mode_single ? ((state == ST_READ) & ~rd_done) : 1'b1);
    wire           add_evt   = trig_evt & last_read & ~en_set;
    wire           finish    = wr_done & last_unit & ~en_stop;
    wire [16:0]    src_step  = step_addr(src, src_fixed, unit_wide);
    wire [16:0]    dst_step  = step_addr(dst, dst_fixed, unit_wide);

    // next address and count values, software writes take lane by lane
    wire [16:0]    src_hw    = rd_done ? src_step : src;
    wire [16:0]    dst_hw    = wr_done ? dst_step : dst;
    wire [16:0]    next_src  = {wr_src_hi ? w_byte[0] : src_hw[16],
                                wr_src_md ? w_byte : src_hw[15:8],
                                wr_src_lo ? w_byte : src_hw[7:0]};
    wire [16:0]    next_dst  = {wr_dst_hi ? w_byte[0] : dst_hw[16],
                                wr_dst_md ? w_byte : dst_hw[15:8],
                                wr_dst_lo ? w_byte : dst_hw[7:0]};
    wire [9:0]     cnt_hw    = wr_done ? count - CNT_LAST : count;
    wire [9:0]     next_cnt  = {wr_cnt_hi ? w_byte[1:0] : cnt_hw[9:8],
                                wr_cnt_lo ? w_byte : cnt_hw[7:0]};

    // ****************************************
    // register bus slave
    // ****************************************
    // write address and data are taken in either order; response follows both
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
            aw_addr   <= 16'h0000;
            w_byte    <= 8'h00;
            w_lane0   <= 1'b0;
        end else begin
            aw_full   <= next_aw_full;
            w_full    <= next_w_full;
            o_awready <= ~next_aw_full & ~next_bvalid;
            o_wready  <= ~next_w_full & ~next_bvalid;
            o_bvalid  <= next_bvalid;
            if (wr_fire) begin
                o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (aw_take) begin
                aw_addr <= i_awaddr;
            end
            if (w_take) begin
                w_byte  <= i_wdata[7:0];
                w_lane0 <= i_wstrb[0];
            end
        end
    end

    // reads answer one cycle after the address is taken
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= RESP_OKAY;
        end else begin
            o_arready <= ~next_rvalid;
            o_rvalid  <= next_rvalid;
            if (ar_take) begin
                o_rdata <= {24'h000000, rd_ok ? rd_byte : 8'h00};
                o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // setup registers
    // ****************************************
    // setup is not interlocked against enable; software keeps it still
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trig_sel    <= TRIG_SOFTWARE;
            src_fixed   <= 1'b0;
            dst_fixed   <= 1'b0;
            unit_wide   <= 1'b0;
            mode_single <= 1'b0;
            src         <= ADDR_RESET;
            dst         <= ADDR_RESET;
            count       <= CNT_RESET;
        end else begin
            if (wr_trig) begin
                trig_sel  <= w_byte[4:0];
                src_fixed <= w_byte[BIT_SRC_FIXED];
            end
            if (wr_mode) begin
                unit_wide   <= w_byte[BIT_UNIT_SIZE];
                mode_single <= w_byte[BIT_MODE];
                dst_fixed   <= w_byte[BIT_DST_FIXED];
            end
            src   <= next_src;
            dst   <= next_dst;
            count <= next_cnt;
        end
    end

    // ****************************************
    // flags and events
    // ****************************************
    // error set wins over the clear caused by an enable write
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable       <= 1'b0;
            error_flag   <= 1'b0;
            last_read    <= 1'b0;
            o_done_irq   <= 1'b0;
            o_addreq_irq <= 1'b0;
            o_error_irq  <= 1'b0;
        end else begin
            enable       <= wr_enreg ? w_byte[BIT_ENABLE]
                                     : (enable & ~finish);
            error_flag   <= err_evt | (error_flag & ~wr_enreg);
            last_read    <= (rd_done & last_unit) | (last_read & ~en_set);
            o_done_irq   <= finish;
            o_addreq_irq <= add_evt;
            o_error_irq  <= err_evt;
        end
    end

    // ****************************************
    // transfer sequencer
    // ****************************************
    // a stop write aborts even a memory request that is still waiting
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state       <= ST_IDLE;
            busy        <= 1'b0;
            o_mem_valid <= 1'b0;
            o_mem       <= '0;
            data_hold   <= 16'h0000;
        end else if (en_stop) begin
            state       <= ST_IDLE;
            busy        <= 1'b0;
            o_mem_valid <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (en_set) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (start) begin
                        state       <= ST_READ;
                        busy        <= 1'b1;
                        o_mem_valid <= 1'b1;
                        o_mem       <= '{we: 1'b0, wide: unit_wide, addr: src, wdata: 16'h0000};
                    end
                end
                ST_READ: begin
                    if (mem_done) begin
                        state     <= ST_WRITE;
                        data_hold <= i_mem_rdata;
                        o_mem     <= '{we: 1'b1, wide: unit_wide, addr: dst, wdata: i_mem_rdata};
                    end
                end
                ST_WRITE: begin
                    if (mem_done) begin
                        if (last_unit || mode_single) begin
                            state       <= last_unit ? ST_IDLE : ST_WAIT;
                            busy        <= 1'b0;
                            o_mem_valid <= 1'b0;
                        end else begin
                            state <= ST_READ;
                            o_mem <= '{we: 1'b0, wide: unit_wide, addr: src, wdata: data_hold};
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_dst_fixed_hold: assert property (wr_done && dst_fixed
        && !wr_dst_lo && !wr_dst_md && !wr_dst_hi |=> $stable(dst))
        else $error("fixed destination moved");
    a_dst_step_size: assert property (wr_done && !dst_fixed
        && !wr_dst_lo && !wr_dst_md && !wr_dst_hi
        |=> dst == $past(dst) + (unit_wide ? 17'h2 : 17'h1))
        else $error("destination step wrong");
    a_done_clears_en: assert property (finish && !wr_enreg
        |=> !enable && o_done_irq) else $error("enable not cleared at end");
    a_stop_goes_idle: assert property (en_stop
        |=> state == ST_IDLE && !busy && !o_mem_valid) else $error("emergency stop ignored");
    a_err_write_clear: assert property (wr_enreg && !err_evt |=> !error_flag)
        else $error("error flag not cleared");
    a_busy_on_start: assert property (start
        |=> busy && state == ST_READ && o_mem_valid) else $error("busy not set on start");
    a_single_busy_end: assert property (wr_done && mode_single && !en_stop
        |=> !busy) else $error("busy held after single unit");
    a_count_dec: assert property (wr_done && !wr_cnt_lo && !wr_cnt_hi
        |=> count == $past(count) - 10'h1) else $error("count not decremented");
    a_addreq_raise: assert property (add_evt |=> o_addreq_irq)
        else $error("extra request not flagged");
    a_error_raise: assert property (err_evt |=> o_error_irq && error_flag)
        else $error("error not flagged");

    c_done:   cover property (finish);
    c_error:  cover property (err_evt);
    c_addreq: cover property (add_evt);
    c_burst:  cover property (wr_done && !mode_single && !last_unit);

endmodule

/* verif/sdma_mem_model.sv */
`timescale 1ns/1ps
// ****************************************
// memory bus partner
// ****************************************
module sdma_mem_model
    import sdma_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_rst_n,
    input  wire logic          i_valid,
    input  wire sdma_mem_req_t i_req,
    input  wire logic [3:0]    i_delay,
    output logic               o_ready,
    output logic [15:0]        o_rdata
);
    logic [3:0] waited;

    // answer after i_delay cycles; data bus scrambles outside answers so stale reads show
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ready <= 1'h0;
            o_rdata <= 16'h0000;
            waited  <= 4'h0;
        end else if (o_ready || !i_valid) begin
            o_ready <= 1'h0;
            o_rdata <= ~o_rdata;
            waited  <= 4'h0;
        end else if (waited >= i_delay) begin
            o_ready <= 1'h1;
            o_rdata <= {~i_req.addr[7:0], i_req.addr[7:0] ^ 8'h3C};
        end else begin
            waited  <= waited + 4'h1;
            o_rdata <= ~o_rdata;
        end
    end
endmodule

/* verif/tb_sdma_top.sv */
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module tb_sdma_top
    import sdma_pkg::*;
;
    logic          clk = 1'h0, rst_n = 1'h0, aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0;
    logic          ar_v = 1'h0, r_r = 1'h0;
    logic [15:0]   aw_a = 16'h0000, ar_a = 16'h0000;
    logic [31:0]   w_d = 32'h0000_0000, trig = 32'h0000_0000;
    logic [3:0]    delay = 4'h0;
    logic          awready, wready, bvalid, arready, rvalid, mem_valid, mem_ready;
    logic          done_q, add_q, err_q;
    logic [1:0]    bresp, rresp;
    logic [31:0]   rdata;
    logic [15:0]   mem_rdata, wr_data;
    logic [16:0]   wr_addr;
    logic [1:0]    b_got;
    logic          wr_wide;
    sdma_mem_req_t mem;
    int            n_done = 0, n_add = 0, n_err = 0, n_wr = 0, err_total = 0, checked = 0;

    sdma_top i_dut (.i_clock(clk), .i_rst_n(rst_n), .i_awaddr(aw_a), .i_awvalid(aw_v),
        .o_awready(awready), .i_wdata(w_d), .i_wstrb(4'hF), .i_wvalid(w_v), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(b_r), .i_araddr(ar_a), .i_arvalid(ar_v),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(r_r), .o_mem_valid(mem_valid), .o_mem(mem), .i_mem_ready(mem_ready),
        .i_mem_rdata(mem_rdata), .i_trigger(trig), .o_done_irq(done_q),
        .o_addreq_irq(add_q), .o_error_irq(err_q));
    sdma_mem_model i_mem (.i_clock(clk), .i_rst_n(rst_n), .i_valid(mem_valid), .i_req(mem),
        .i_delay(delay), .o_ready(mem_ready), .o_rdata(mem_rdata));

    // clock
    always #4 clk = ~clk;

    // pulse and write counters, sampled at the edge the design sees
    always @(posedge clk) begin
        if (done_q === 1'h1) n_done++;
        if (add_q === 1'h1) n_add++;
        if (err_q === 1'h1) n_err++;
        if (mem_valid === 1'h1 && mem_ready === 1'h1 && mem.we === 1'h1) begin
            n_wr++;
            wr_addr = mem.addr;
            wr_data = mem.wdata;
            wr_wide = mem.wide;
        end
    end

    task automatic give_verdict();
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic hang();
        err_total++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // write: extra edge at the end so the next call never re-drives in the same step
    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        int n;
        aw_v <= 1'h1;
        w_v  <= 1'h1;
        b_r  <= 1'h1;
        aw_a <= {idx, 2'h0};
        w_d  <= {24'h000000, d};
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awready) aw_v <= 1'h0;
            if (wready) w_v <= 1'h0;
            if (bvalid) break;
        end
        b_got = bresp;
        b_r <= 1'h0;
        @(posedge clk);
        if (n == 60) hang();
    endtask

    task automatic rd(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        ar_v <= 1'h1;
        r_r  <= 1'h1;
        ar_a <= {idx, 2'h0};
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arready) ar_v <= 1'h0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        r_r <= 1'h0;
        @(posedge clk);
        if (n == 60) hang();
    endtask

    task automatic rc(input logic [13:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        chk(d, {24'h000000, exp});
    endtask

    task automatic wait_for(ref int v, input int t);
        int n;
        for (n = 0; n < 400 && v < t; n++) @(posedge clk);
        if (v < t) hang();
    endtask

    task automatic pulse(input int b);
        trig[b] <= 1'h1;
        @(posedge clk);
        trig <= 32'h0000_0000;
        @(posedge clk);
    endtask

    // setup only while the engine is idle
    task automatic setup(input logic [16:0] s, input logic [16:0] d, input logic [9:0] c,
                         input logic [7:0] mode, input logic [7:0] sel);
        wr(REG_TRIG_IDX, sel);
        wr(REG_MODE_IDX, mode);
        wr(REG_SRC_LO_IDX, s[7:0]);
        wr(REG_SRC_MID_IDX, s[15:8]);
        wr(REG_SRC_HI_IDX, {7'h00, s[16]});
        wr(REG_DST_LO_IDX, d[7:0]);
        wr(REG_DST_MID_IDX, d[15:8]);
        wr(REG_DST_HI_IDX, {7'h00, d[16]});
        wr(REG_CNT_LO_IDX, c[7:0]);
        wr(REG_CNT_HI_IDX, {6'h00, c[9:8]});
    endtask

    // reset values, unmapped holes, read-only status
    task automatic scen_regs();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 14; i++) begin
            rd(14'h3E00 + 14'(i), d, r);
            chk(d, 32'h0000_0000);
            chk({30'h0, r}, {30'h0, (i == 7 || i == 11) ? RESP_SLVERR : RESP_OKAY});
        end
        wr(REG_STAT_IDX, 8'hFF);
        chk({30'h0, b_got}, {30'h0, RESP_OKAY});
        rc(REG_STAT_IDX, 8'h00);
        wr(14'h3E07, 8'h55);
        chk({30'h0, b_got}, {30'h0, RESP_SLVERR});
    endtask

    // software-started byte burst crossing a byte boundary of the source
    task automatic scen_burst();
        delay <= 4'h4;
        setup(17'h112FE, 17'h00480, 10'h003, 8'h00, 8'h00);
        wr(REG_EN_IDX, 8'h01);
        rc(REG_STAT_IDX, 8'h01);
        wait_for(n_done, 1);
        chk(n_wr, 3);
        chk({15'h0, wr_addr}, 32'h0000_0482);
        chk({24'h0, wr_data[7:0]}, 32'h0000_003C);
        chk({31'h0, wr_wide}, 32'h0000_0000);
        rc(REG_SRC_LO_IDX, 8'h01);
        rc(REG_SRC_MID_IDX, 8'h13);
        rc(REG_SRC_HI_IDX, 8'h01);
        rc(REG_DST_LO_IDX, 8'h83);
        rc(REG_CNT_LO_IDX, 8'h00);
        rc(REG_EN_IDX, 8'h00);
        rc(REG_STAT_IDX, 8'h00);
    endtask

    // single mode, trigger input 5, halfwords, destination fixed
    task automatic scen_single();
        delay <= 4'h0;
        setup(17'h00200, 17'h00300, 10'h002, 8'h2A, 8'h05);
        wr(REG_EN_IDX, 8'h01);
        repeat (6) @(posedge clk);
        chk(n_wr, 3);
        rc(REG_STAT_IDX, 8'h00);
        pulse(5);
        wait_for(n_wr, 4);
        chk({15'h0, wr_addr}, 32'h0000_0300);
        chk({16'h0, wr_data}, 32'h0000_FF3C);
        chk({31'h0, wr_wide}, 32'h0000_0001);
        rc(REG_STAT_IDX, 8'h00);
        rc(REG_SRC_LO_IDX, 8'h02);
        rc(REG_CNT_LO_IDX, 8'h01);
        pulse(5);
        wait_for(n_done, 2);
        rc(REG_DST_LO_IDX, 8'h00);
        rc(REG_EN_IDX, 8'h00);
        pulse(5);
        repeat (3) @(posedge clk);
        chk(n_add, 1);
        chk(n_err, 0);
    endtask

    // second trigger before the read completes, then emergency stop
    task automatic scen_error();
        logic [31:0] d;
        logic [1:0]  r;
        int          w;
        delay <= 4'h6;
        setup(17'h00010, 17'h00020, 10'h002, 8'h08, 8'h05);
        wr(REG_EN_IDX, 8'h01);
        pulse(5);
        pulse(5);
        repeat (2) @(posedge clk);
        chk(n_err, 1);
        rd(REG_STAT_IDX, d, r);
        chk(d & 32'h0000_0010, 32'h0000_0010);
        wr(REG_EN_IDX, 8'h00);
        rc(REG_STAT_IDX, 8'h00);
        w = n_wr;
        repeat (40) @(posedge clk);
        chk(n_wr, w);
        rc(REG_EN_IDX, 8'h00);
    endtask

    // burst on trigger input 5: retrigger mid-burst is an error, one after the end asks again
    task automatic scen_burst_trig();
        delay <= 4'h2;
        setup(17'h00040, 17'h00050, 10'h002, 8'h00, 8'h05);
        wr(REG_EN_IDX, 8'h01);
        pulse(5);
        pulse(5);
        wait_for(n_done, 3);
        pulse(5);
        repeat (3) @(posedge clk);
        chk(n_err, 2);
        chk(n_add, 2);
        rc(REG_STAT_IDX, 8'h10);
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        scen_regs();
        scen_burst();
        scen_single();
        scen_error();
        scen_burst_trig();
        give_verdict();
    end
endmodule
